// ==== rtl/samseq_top.sv ====
// serial converter sequencer with result fifo

// --------------------------------------------------------------------
// result fifo
// --------------------------------------------------------------------
module samseq_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // honest flags from the occupancy count
   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr_reg];

   // storage, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end
endmodule // samseq_fifo

// --------------------------------------------------------------------
// sequencer
// --------------------------------------------------------------------
// Operation
// - falling chip select starts a cycle awaiting start bit and address.
// - serial input sampled on each rising clock while addressing.
// - first sampled one is the start bit; leading zeros are dropped. single-input variant starts on the first rising clock.
// - none, two or three address bits follow the start bit, set by variant.
// - after the last address bit a half-clock settling gap is inserted.
// - conversion flag rises at that gap; serial input then ignored.
// - output leaves high impedance and drives zero for the settling clock.
// - each decision is one when input exceeds the trial level.
// - each decision goes out on the falling edge after it, MSB first.
// - done after eight clocks; conversion flag drops half a clock later.
// - result goes to shift register; enable low shifts LSB first, high holds.
// - variants without enable repeat LSB first right after MSB stream.
// - after the last bit output is low until chip select rises.
// - single-input variant gives MSB first only, no repeat.
// - all registers clear after chip select high for the minimum time; the result fifo keeps its entries.
// - input only watched during addressing, while output is high impedance.
// - two-input single-ended: parity bit picks input zero or one.
// - single-ended negative input is analog ground.
// - each conversion takes a fresh selection, no memory of the last.
// - differential pairs are only even input with next odd input.
module samseq_top #(
   parameter int NUM_INPUTS = 4,
   parameter bit HAS_SE = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // serial link pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in,
   input wire logic lsb_shift_enable_n,
   output logic dout,
   output logic dout_oe_n,
   output logic conversion_active,
   // analog core
   input wire logic comp_above,
   output logic [7:0] trial_code,
   output samseq_pkg::samseq_mux_sel_type mux_sel,
   // parallel results
   output logic result_valid,
   input wire logic result_ready,
   output logic [7:0] result_data
);
   localparam int ADDR_BITS = (NUM_INPUTS == 1) ? 0 :
                              (NUM_INPUTS == 2) ? 2 : 3;
   localparam logic [1:0] ADDR_LAST = 2'(ADDR_BITS - 1);

   samseq_pkg::samseq_pins_type s1_reg, s2_reg, s3_reg, pin_reg;
   samseq_pkg::samseq_state_type state_reg;
   logic sclk_prev_reg;
   logic rise, fall, cs_high;
   logic [7:0] desel_cnt_reg;
   logic cleared_reg;
   logic [2:0] addr_reg, addr_next;
   logic [1:0] acnt_reg;
   logic [7:0] sar_reg, mask_reg, shift_reg;
   logic bit_reg;
   logic [2:0] lsb_cnt_reg;
   logic fifo_ready, push;
   logic start_ok, sgl, odd, sel1, shift_now;

   // ----------------------------------------------------------------
   // pin synchronisers and clock edges
   // ----------------------------------------------------------------
   // three stages; a level counts once stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s1_reg <= samseq_pkg::PINS_RESET;
         s2_reg <= samseq_pkg::PINS_RESET;
         s3_reg <= samseq_pkg::PINS_RESET;
      end else begin
         s1_reg <= {lsb_shift_enable_n, serial_in, cs_n, sclk};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // per-bit agreement filter
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_reg <= samseq_pkg::PINS_RESET;
         sclk_prev_reg <= 1'b0;
      end else begin
         pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
         sclk_prev_reg <= pin_reg.sclk;
      end
   end

   assign rise = pin_reg.sclk & ~sclk_prev_reg;
   assign fall = ~pin_reg.sclk & sclk_prev_reg;
   assign cs_high = pin_reg.cs_n;

   // ----------------------------------------------------------------
   // deselect timer
   // ----------------------------------------------------------------
   // sar_reg and shift_reg only clear once chip select stayed high long enough
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         desel_cnt_reg <= samseq_pkg::DESEL_RESET;
         cleared_reg <= 1'b0;
      end else if (!cs_high) begin
         desel_cnt_reg <= samseq_pkg::DESEL_RESET;
      end else if (desel_cnt_reg !=
                   8'(samseq_pkg::IDLE_HIGH_MIN_CYC)) begin
         desel_cnt_reg <= desel_cnt_reg + 8'h01;
      end else begin
         cleared_reg <= 1'b1;
      end
      if (!sys_rst && state_reg == samseq_pkg::ST_WAIT) begin
         cleared_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // fifo full blocks a new start so no result is ever dropped
   assign start_ok = fifo_ready &&
                     ((ADDR_BITS == 0) || pin_reg.din);
   assign addr_next = {addr_reg[1:0], pin_reg.din};
   assign sgl = (ADDR_BITS == 3) ? addr_next[2] : addr_next[1];
   assign odd = (ADDR_BITS == 3) ? addr_next[1] : addr_next[0];
   assign sel1 = (ADDR_BITS == 3) ? addr_next[0] : 1'b0;

   // ----------------------------------------------------------------
   // sequence control
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= samseq_pkg::ST_IDLE;
      end else if (cs_high) begin
         state_reg <= samseq_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            samseq_pkg::ST_IDLE: begin
               // a low without a full deselect is ignored
               if (cleared_reg) state_reg <= samseq_pkg::ST_WAIT;
            end
            samseq_pkg::ST_WAIT: begin
               if (rise && start_ok) begin
                  state_reg <= (ADDR_BITS == 0) ? samseq_pkg::ST_SETTLE
                                                : samseq_pkg::ST_ADDR;
               end
            end
            samseq_pkg::ST_ADDR: begin
               if (rise && acnt_reg == ADDR_LAST) begin
                  state_reg <= samseq_pkg::ST_SETTLE;
               end
            end
            samseq_pkg::ST_SETTLE: begin
               if (fall) state_reg <= samseq_pkg::ST_CONV;
            end
            samseq_pkg::ST_CONV: begin
               if (fall && mask_reg == samseq_pkg::SAR_RESET) begin
                  state_reg <= (NUM_INPUTS == 1) ? samseq_pkg::ST_TAIL
                                                 : samseq_pkg::ST_LSB;
               end
            end
            samseq_pkg::ST_LSB: begin
               if (shift_now && lsb_cnt_reg == samseq_pkg::LSB_SHIFTS) begin
                  state_reg <= samseq_pkg::ST_TAIL;
               end
            end
            samseq_pkg::ST_TAIL: state_reg <= samseq_pkg::ST_TAIL;
            default: state_reg <= samseq_pkg::ST_IDLE;
         endcase
      end
   end

   // address shift register; input sampled only while addressing
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         addr_reg <= samseq_pkg::ADDR_RESET;
         acnt_reg <= 2'h0;
      end else if (state_reg == samseq_pkg::ST_IDLE && cs_high &&
                   desel_cnt_reg == 8'(samseq_pkg::IDLE_HIGH_MIN_CYC)) begin
         addr_reg <= samseq_pkg::ADDR_RESET;
         acnt_reg <= 2'h0;
      end else if (!cs_high && rise &&
                   state_reg == samseq_pkg::ST_ADDR) begin
         addr_reg <= addr_next;
         acnt_reg <= acnt_reg + 2'h1;
      end
   end

   // channel selection latched fresh for each conversion
   always_ff @(posedge clk_sys) begin
      if (sys_rst || cs_high) begin
         mux_sel <= samseq_pkg::MUX_SEL_RESET;
      end else if (rise && state_reg == samseq_pkg::ST_WAIT &&
                   start_ok && ADDR_BITS == 0) begin
         mux_sel.pos_channel <= 2'h0;
         mux_sel.neg_channel <= 2'h1;
         mux_sel.neg_is_ground <= 1'b0;
      end else if (rise && state_reg == samseq_pkg::ST_ADDR &&
                   acnt_reg == ADDR_LAST) begin
         mux_sel.pos_channel <= {sel1, odd};
         mux_sel.neg_channel <= {sel1, ~odd};
         mux_sel.neg_is_ground <= sgl;
      end
   end

   // ----------------------------------------------------------------
   // successive approximation
   // ----------------------------------------------------------------
   // trial bit sits in sar_reg; a low comparator clears it again
   always_ff @(posedge clk_sys) begin
      if (sys_rst || (cs_high && cleared_reg)) begin
         sar_reg <= samseq_pkg::SAR_RESET;
         mask_reg <= samseq_pkg::SAR_RESET;
         bit_reg <= 1'b0;
      end else if (!cs_high && fall &&
                   state_reg == samseq_pkg::ST_SETTLE) begin
         sar_reg <= samseq_pkg::MASK_FIRST;
         mask_reg <= samseq_pkg::MASK_FIRST;
      end else if (!cs_high && rise &&
                   state_reg == samseq_pkg::ST_CONV) begin
         bit_reg <= comp_above;
         sar_reg <= (comp_above ? sar_reg : (sar_reg & ~mask_reg)) |
                    (mask_reg >> 1);
         mask_reg <= mask_reg >> 1;
      end
   end

   assign trial_code = sar_reg;

   // ----------------------------------------------------------------
   // output shift register and serial output
   // ----------------------------------------------------------------
   assign shift_now = fall && state_reg == samseq_pkg::ST_LSB &&
                      (!HAS_SE || !pin_reg.se_n);
   assign push = !cs_high && fall && state_reg == samseq_pkg::ST_CONV &&
                 mask_reg == samseq_pkg::SAR_RESET;

   always_ff @(posedge clk_sys) begin
      if (sys_rst || (cs_high && cleared_reg)) begin
         shift_reg <= samseq_pkg::SAR_RESET;
         lsb_cnt_reg <= 3'h0;
      end else if (push) begin
         shift_reg <= sar_reg;
         lsb_cnt_reg <= 3'h0;
      end else if (!cs_high && shift_now &&
                   lsb_cnt_reg != samseq_pkg::LSB_SHIFTS) begin
         shift_reg <= shift_reg >> 1;
         lsb_cnt_reg <= lsb_cnt_reg + 3'h1;
      end
   end

   // output driver; the controller may share the wire while it floats
   always_ff @(posedge clk_sys) begin
      if (sys_rst || cs_high) begin
         dout <= 1'b0;
         dout_oe_n <= 1'b1;
      end else if (fall) begin
         case (state_reg)
            samseq_pkg::ST_SETTLE: begin
               dout <= 1'b0;
               dout_oe_n <= 1'b0;
            end
            samseq_pkg::ST_CONV: dout <= bit_reg;
            samseq_pkg::ST_LSB: begin
               if (shift_now) begin
                  dout <= (lsb_cnt_reg == samseq_pkg::LSB_SHIFTS) ?
                          1'b0 : shift_reg[1];
               end
            end
            samseq_pkg::ST_TAIL: dout <= 1'b0;
            default: dout <= dout;
         endcase
      end
   end

   // conversion flag: up at the settle gap, down half a clock after end
   always_ff @(posedge clk_sys) begin
      if (sys_rst || cs_high) begin
         conversion_active <= 1'b0;
      end else if (rise && ((state_reg == samseq_pkg::ST_ADDR &&
                   acnt_reg == ADDR_LAST) ||
                   (state_reg == samseq_pkg::ST_WAIT && start_ok &&
                   ADDR_BITS == 0))) begin
         conversion_active <= 1'b1;
      end else if (push) begin
         conversion_active <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // result buffer
   // ----------------------------------------------------------------
   samseq_fifo #(
      .WIDTH(samseq_pkg::FIFO_WIDTH),
      .DEPTH(samseq_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(sar_reg),
      .out_valid(result_valid),
      .out_ready(result_ready),
      .out_data(result_data)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   float_abort_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cs_high |=> dout_oe_n) else $error("output not floated");
   settle_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(dout_oe_n) |-> !dout) else $error("no leading zero");
   active_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(dout_oe_n) |-> conversion_active)
      else $error("driving before flag");
   flag_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      push |=> !conversion_active && dout == $past(sar_reg[0]))
      else $error("flag or lsb wrong at end");
   din_ignore_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_reg == samseq_pkg::ST_CONV || state_reg == samseq_pkg::ST_LSB)
      |=> $stable(addr_reg)) else $error("input taken late");
   tail_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_reg == samseq_pkg::ST_TAIL && fall && !cs_high) |=> !dout)
      else $error("tail not low");
   clear_all_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cs_high && cleared_reg) |=> sar_reg == 8'h00 && shift_reg == 8'h00)
      else $error("registers not cleared");
   decide_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (rise && !cs_high && state_reg == samseq_pkg::ST_CONV && !comp_above)
      |=> (sar_reg & $past(mask_reg)) == 8'h00)
      else $error("low decision kept");
   lsb_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (HAS_SE && fall && pin_reg.se_n && !cs_high &&
       state_reg == samseq_pkg::ST_LSB) |=> $stable(dout))
      else $error("lsb not held");
   start_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ADDR_BITS != 0 && rise && !pin_reg.din && !cs_high &&
       state_reg == samseq_pkg::ST_WAIT) |=> state_reg == samseq_pkg::ST_WAIT)
      else $error("zero taken as start");
endmodule // samseq_top

// ==== include/samseq_pkg.sv ====
// package: constants and types for the serial converter sequencer
package samseq_pkg;
   // ----------------------------------------------------------------
   // sizes and timing
   // ----------------------------------------------------------------
   localparam int SAR_BITS = 8;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CLK_PERIOD_NS = 8;
   localparam int IDLE_HIGH_MIN_NS = 200;
   // least time rounds up to whole cycles
   localparam int IDLE_HIGH_MIN_CYC =
      (IDLE_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] SAR_RESET = 8'h00;
   localparam logic [7:0] MASK_FIRST = 8'h80;
   localparam logic [2:0] LSB_SHIFTS = 3'h7;
   localparam logic [2:0] ADDR_RESET = 3'h0;
   localparam logic [7:0] DESEL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_WAIT   = 7'h02,
      ST_ADDR   = 7'h04,
      ST_SETTLE = 7'h08,
      ST_CONV   = 7'h10,
      ST_LSB    = 7'h20,
      ST_TAIL   = 7'h40
   } samseq_state_type;

   typedef struct packed {
      logic se_n;
      logic din;
      logic cs_n;
      logic sclk;
   } samseq_pins_type;

   typedef struct packed {
      logic [1:0] pos_channel;
      logic [1:0] neg_channel;
      logic neg_is_ground;
   } samseq_mux_sel_type;

   localparam samseq_pins_type PINS_RESET = 4'ha;
   localparam samseq_mux_sel_type MUX_SEL_RESET = 5'h00;
endpackage

// ==== bench/samseq_ctrl_model.sv ====
// controller model that drives the serial link of the sequencer
// --------------------------------------------------------------------
// controller model
// --------------------------------------------------------------------
module samseq_ctrl_model (
   // time base
   input wire logic clk_sys,
   // link pins toward the sequencer
   output logic sclk,
   output logic cs_n,
   output logic serial_in,
   output logic lsb_shift_enable_n,
   // pins from the sequencer
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic conversion_active,
   // serial output of the second, self-shifting sequencer
   input wire logic dout_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // half period well above the four cycles the pin filters need
   localparam int HALF = 10;
   localparam int LAST = 19;
   logic cap_d [0:LAST];
   logic cap_oe [0:LAST];
   logic cap_ca [0:LAST];
   logic cap_b [0:LAST];
   int abort_at;

   // idle: serial clock parked low, chip deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      serial_in = 1'b0;
      lsb_shift_enable_n = 1'b1;
      abort_at = -1;
   end

   task automatic half_wait();
      repeat (HALF) @(negedge clk_sys);
   endtask

   // data is set while the clock is low, the device takes it on the rise
   task automatic send_bit(input logic b);
      serial_in = b;
      half_wait();
      sclk = 1'b1;
      half_wait();
      sclk = 1'b0;
   endtask

   // one whole conversion; addr is {single, odd, select}
   task automatic frame(input logic [2:0] addr, input int hold);
      cs_n = 1'b0;
      repeat (12) @(negedge clk_sys);
      send_bit(1'b0);
      send_bit(1'b0);
      send_bit(1'b1);
      for (int i = 2; i >= 0; i--) begin
         send_bit(addr[i]);
      end
      for (int k = 0; k <= LAST; k++) begin
         // input keeps toggling so a stray sample would show
         serial_in = ~serial_in;
         half_wait();
         cap_d[k] = dout;
         cap_oe[k] = dout_oe_n;
         cap_ca[k] = conversion_active;
         cap_b[k] = dout_b;
         if (k == abort_at) begin
            break;
         end
         sclk = 1'b1;
         // enable is set half a period ahead of the fall that uses it
         lsb_shift_enable_n = logic'(k + 1 <= 8 + hold);
         half_wait();
         sclk = 1'b0;
      end
      cs_n = 1'b1;
   endtask
endmodule // samseq_ctrl_model

// ==== bench/samseq_top_tb.sv ====
// self-checking bench for the serial converter sequencer
// --------------------------------------------------------------------
// bench top
// --------------------------------------------------------------------
module samseq_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys;
   logic sys_rst;
   logic sclk;
   logic cs_n;
   logic serial_in;
   logic lsb_shift_enable_n;
   logic dout;
   logic dout_oe_n;
   logic conversion_active;
   logic comp_above;
   logic [7:0] trial_code;
   samseq_pkg::samseq_mux_sel_type mux_sel;
   logic result_valid;
   logic result_ready;
   logic [7:0] result_data;
   // second sequencer: two inputs, no shift enable, on the same link
   logic dout_b;
   logic comp_above_b;
   logic [7:0] trial_code_b;
   samseq_pkg::samseq_mux_sel_type mux_sel_b;
   logic result_valid_b;
   logic [7:0] result_data_b;
   logic [7:0] vin;
   logic [7:0] exp_q [$];
   int err_total;
   int check_count;

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ideal comparator standing in for the analog core
   assign comp_above = (vin > trial_code);
   assign comp_above_b = (vin > trial_code_b);

   samseq_top #(.NUM_INPUTS(4), .HAS_SE(1'b1)) i_samseq_top (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
      .serial_in(serial_in), .lsb_shift_enable_n(lsb_shift_enable_n),
      .dout(dout), .dout_oe_n(dout_oe_n),
      .conversion_active(conversion_active), .comp_above(comp_above),
      .trial_code(trial_code), .mux_sel(mux_sel),
      .result_valid(result_valid), .result_ready(result_ready),
      .result_data(result_data));

   samseq_ctrl_model i_samseq_ctrl_model (
      .clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
      .lsb_shift_enable_n(lsb_shift_enable_n), .dout(dout),
      .dout_oe_n(dout_oe_n), .conversion_active(conversion_active),
      .dout_b(dout_b));

   // two address bits only: it answers one clock early, and the third
   // address bit lands mid-conversion where it must be ignored
   samseq_top #(.NUM_INPUTS(2), .HAS_SE(1'b0)) i_samseq_top_b (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
      .serial_in(serial_in), .lsb_shift_enable_n(lsb_shift_enable_n),
      .dout(dout_b), .dout_oe_n(), .conversion_active(),
      .comp_above(comp_above_b), .trial_code(trial_code_b),
      .mux_sel(mux_sel_b), .result_valid(result_valid_b),
      .result_ready(result_ready), .result_data(result_data_b));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // approximation worked out bit by bit from the comparator rule
   function automatic logic [7:0] sar_code(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         if (v > (r | (8'h01 << i))) r = r | (8'h01 << i);
      end
      return r;
   endfunction

   // pin value after fall k: lead zero, msb stream, hold, lsb stream
   function automatic logic exp_bit(input logic [7:0] r, input int k,
                                    input int hold);
      if (k == 0) return 1'b0;
      if (k <= 8) return r[8-k];
      if (k <= 8 + hold) return r[0];
      if (k <= 15 + hold) return r[k-8-hold];
      return 1'b0;
   endfunction

   task automatic run_conv(input logic [2:0] a, input logic [7:0] v,
                           input int hold, input logic refused);
      logic [7:0] r;
      r = sar_code(v);
      vin = v;
      i_samseq_ctrl_model.frame(a, hold);
      for (int k = 0; k <= 19; k++) begin
         if (refused) begin
            check(i_samseq_ctrl_model.cap_oe[k], 8'h01);
            check(i_samseq_ctrl_model.cap_ca[k], 8'h00);
         end else begin
            check(i_samseq_ctrl_model.cap_oe[k], 8'h00);
            check(i_samseq_ctrl_model.cap_d[k],
                  exp_bit(r, k, hold));
            check(i_samseq_ctrl_model.cap_b[k],
                  exp_bit(r, k + 1, 0));
            check(i_samseq_ctrl_model.cap_ca[k], logic'(k < 8));
         end
      end
      if (!refused) begin
         check(mux_sel.pos_channel, {a[0], a[1]});
         check(mux_sel.neg_is_ground, a[2]);
         check(mux_sel_b.pos_channel, {1'b0, a[1]});
         check(mux_sel_b.neg_is_ground, a[2]);
         if (!a[2]) check(mux_sel.neg_channel, {a[0], ~a[1]});
         exp_q.push_back(r);
      end
      repeat (10) @(negedge clk_sys);
      check(dout_oe_n, 8'h01);
      check(conversion_active, 8'h00);
      // deselect longer than the minimum so the next frame is accepted
      repeat (40) @(negedge clk_sys);
   endtask

   // pop one result, then stall a cycle before the next
   task automatic pop(input logic [7:0] e);
      int n;
      n = 0;
      while (result_valid !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 50) begin
         err_total++;
         $display("ERROR at %0t: result wait timed out", $time);
         wrap_up();
      end
      check(result_data, e);
      check(result_data_b, e);
      result_ready = 1'b1;
      @(negedge clk_sys);
      result_ready = 1'b0;
      @(negedge clk_sys);
   endtask

   // guard against a hung handshake
   initial begin
      #480000;
      err_total++;
      $display("ERROR at %0t: run timed out", $time);
      wrap_up();
   end

   // main sequence: fill fifo over sixteen levels and all eight addresses, refuse, drain, abort
   initial begin
      sys_rst = 1'b1;
      result_ready = 1'b0;
      vin = 8'h00;
      err_total = 0;
      check_count = 0;
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      check(dout_oe_n, 8'h01);
      check(conversion_active, 8'h00);
      check(trial_code, 8'h00);
      check(result_valid, 8'h00);
      repeat (40) @(negedge clk_sys);
      for (int n = 0; n < 16; n++) begin
         run_conv(3'(n), 8'(n * 17), (n >= 8) ? 2 : 0, 1'b0);
      end
      run_conv(3'h5, 8'h40, 0, 1'b1);
      check(result_valid, 8'h01);
      check(result_valid_b, 8'h01);
      while (exp_q.size() > 0) pop(exp_q.pop_front());
      check(result_valid, 8'h00);
      check(result_valid_b, 8'h00);
      i_samseq_ctrl_model.abort_at = 4;
      vin = 8'hc3;
      i_samseq_ctrl_model.frame(3'h0, 0);
      i_samseq_ctrl_model.abort_at = -1;
      repeat (10) @(negedge clk_sys);
      check(dout_oe_n, 8'h01);
      check(conversion_active, 8'h00);
      repeat (40) @(negedge clk_sys);
      run_conv(3'h2, 8'h81, 1, 1'b0);
      pop(exp_q.pop_front());
      check(result_valid, 8'h00);
      check(result_valid_b, 8'h00);
      wrap_up();
   end
endmodule // samseq_top_tb
